// *** include/bcd_counter_pkg.sv ***
/*
 * constants for the presettable up/down decade counter.
 * assumes nothing beyond a single core clock domain.
 */
package bcd_counter_pkg;
    localparam int unsigned CNT_W    = 4;
    localparam logic [3:0]  CNT_ZERO = 4'h0;
    localparam logic [3:0]  CNT_NINE = 4'h9;
    localparam logic [3:0]  CNT_MAX  = 4'hF;
    localparam logic [3:0]  CNT_ONE  = 4'h1;
    localparam logic [3:0]  CNT_TWO      = 4'h2;
    localparam logic [3:0]  CNT_FOUR     = 4'h4;
    localparam logic [3:0]  CNT_SIX      = 4'h6;
    localparam logic [3:0]  CNT_ELEVEN   = 4'hB;
    localparam logic [3:0]  CNT_THIRTEEN = 4'hD;
    localparam logic [3:0]  CNT_FOURTEEN = 4'hE;

    typedef struct packed {
        logic [1:0] up_sync_r;
        logic [1:0] dn_sync_r;
        logic [1:0] ld_sync_r;
        logic [1:0] clr_sync_r;
        logic [3:0] pre_sync0_r;
        logic [3:0] pre_sync1_r;
        logic       up_prev_r;
        logic       dn_prev_r;
        logic [3:0] count_r;
        logic       up_carry_n_r;
        logic       dn_borrow_n_r;
    } ctr_state_t;

    // synchronisers start at idle pin levels, so no false edge on release
    localparam ctr_state_t ST_RESET = '{
        up_sync_r:     2'h3,
        dn_sync_r:     2'h3,
        ld_sync_r:     2'h3,
        clr_sync_r:    2'h0,
        pre_sync0_r:   4'h0,
        pre_sync1_r:   4'h0,
        up_prev_r:     1'h1,
        dn_prev_r:     1'h1,
        count_r:       CNT_ZERO,
        up_carry_n_r:  1'h1,
        dn_borrow_n_r: 1'h1
    };
endpackage

// *** hdl/bcd_up_down_counter.sv ***
/*
 * presettable bcd up/down counter, count clocks sampled as pins.
 * assumes all pins are asynchronous to core_clk and that each pin
 * level is held for at least three core_clk periods.
 */
// What this block does
// - counting steps only on rising edge of a count clock input.
// - up clock pulse increments, down clock pulse decrements; no direction pin.
// - load strobe low copies preset inputs into counter regardless of clocks.
// - clear high forces all four stages to zero without clock edge.
// - normal counting cycles zero to nine; any 4-bit value presettable.
// - up from illegal: 10-11-6, 12-13-4, 14-15-2.
// - down from illegal: 15 down to 10, then 9 and normal.
// - down borrow output pulses low on underflow past zero.
// - up carry output pulses low on overflow past nine.
`timescale 1ns/1ps
module bcd_up_down_counter
    import bcd_counter_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // count clocks (pins)
    input  wire logic count_up_clk,
    input  wire logic count_down_clk,
    // control (pins)
    input  wire logic async_clear,
    input  wire logic load_strobe_n,
    // preset data (pins)
    input  wire logic preset_bit0,
    input  wire logic preset_bit1,
    input  wire logic preset_bit2,
    input  wire logic preset_bit3,
    // count outputs
    output logic      count_bit0,
    output logic      count_bit1,
    output logic      count_bit2,
    output logic      count_bit3,
    // cascade outputs
    output logic      up_carry_out_n,
    output logic      down_borrow_out_n
);
    ctr_state_t st_r;
    ctr_state_t st_nxt;

    // every check below runs on the core clock and sleeps in reset
    default clocking dflt_cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // non-decade codes 10, 12, 14 advance by one, while 11, 13, 15 jump back, giving 10-11-6 style walks
    function automatic logic [3:0] step_up(input logic [3:0] v);
        logic [3:0] r;
        case (v)
            CNT_NINE:     r = CNT_ZERO;
            CNT_ELEVEN:   r = CNT_SIX;
            CNT_THIRTEEN: r = CNT_FOUR;
            CNT_MAX:      r = CNT_TWO;
            default:      r = v + CNT_ONE;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] step_down(input logic [3:0] v);
        logic [3:0] r;
        r = (v == CNT_ZERO) ? CNT_NINE : v - CNT_ONE;
        return r;
    endfunction

    logic up_s;
    logic dn_s;
    logic ld_n_s;
    logic clr_s;
    logic [3:0] pre_s;
    logic up_rise;
    logic dn_rise;

    assign up_s    = st_r.up_sync_r[1];
    assign dn_s    = st_r.dn_sync_r[1];
    assign ld_n_s  = st_r.ld_sync_r[1];
    assign clr_s   = st_r.clr_sync_r[1];
    assign pre_s   = st_r.pre_sync1_r;
    assign up_rise = up_s & ~st_r.up_prev_r;
    assign dn_rise = dn_s & ~st_r.dn_prev_r;

    always_comb begin
        st_nxt = st_r;
        st_nxt.up_sync_r   = {st_r.up_sync_r[0], count_up_clk};
        st_nxt.dn_sync_r   = {st_r.dn_sync_r[0], count_down_clk};
        st_nxt.ld_sync_r   = {st_r.ld_sync_r[0], load_strobe_n};
        st_nxt.clr_sync_r  = {st_r.clr_sync_r[0], async_clear};
        st_nxt.pre_sync0_r = {preset_bit3, preset_bit2,
                              preset_bit1, preset_bit0};
        st_nxt.pre_sync1_r = st_r.pre_sync0_r;
        st_nxt.up_prev_r   = up_s;
        st_nxt.dn_prev_r   = dn_s;
        if (clr_s) begin
            st_nxt.count_r = CNT_ZERO;
        end else if (!ld_n_s) begin
            st_nxt.count_r = pre_s;
        end else if (up_rise && dn_s) begin
            st_nxt.count_r = step_up(st_r.count_r);
        end else if (dn_rise && up_s) begin
            st_nxt.count_r = step_down(st_r.count_r);
        end
        // carry low at nine while up clock low
        st_nxt.up_carry_n_r  = ~(st_nxt.count_r == CNT_NINE && !up_s);
        // borrow low at zero while down clock low
        st_nxt.dn_borrow_n_r = ~(st_nxt.count_r == CNT_ZERO && !dn_s);
    end

    // pins must pass a synchroniser; clear is therefore two cycles late
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_bit0        = st_r.count_r[0];
    assign count_bit1        = st_r.count_r[1];
    assign count_bit2        = st_r.count_r[2];
    assign count_bit3        = st_r.count_r[3];
    assign up_carry_out_n    = st_r.up_carry_n_r;
    assign down_borrow_out_n = st_r.dn_borrow_n_r;

    a_clear_zero: assert property (
        clr_s |=> st_r.count_r == CNT_ZERO
    ) else $error("clear missed");

    a_load_copy: assert property (
        !clr_s && !ld_n_s |=> st_r.count_r == $past(pre_s)
    ) else $error("load missed");

    a_no_spurious: assert property (
        !clr_s && ld_n_s && !up_rise && !dn_rise |=> $stable(st_r.count_r)
    ) else $error("count moved");

    a_up_one: assert property (
        !clr_s && ld_n_s && up_rise && dn_s && st_r.count_r < CNT_NINE
        |=> st_r.count_r == $past(st_r.count_r) + CNT_ONE
    ) else $error("up step wrong");

    a_down_one: assert property (
        !clr_s && ld_n_s && dn_rise && up_s && st_r.count_r != CNT_ZERO
        |=> st_r.count_r == $past(st_r.count_r) - CNT_ONE
    ) else $error("down step wrong");

    a_up_wrap: assert property (
        !clr_s && ld_n_s && up_rise && dn_s && st_r.count_r == CNT_NINE
        |=> st_r.count_r == CNT_ZERO
    ) else $error("up wrap wrong");

    a_down_wrap: assert property (
        !clr_s && ld_n_s && dn_rise && up_s && st_r.count_r == CNT_ZERO
        |=> st_r.count_r == CNT_NINE
    ) else $error("down wrap wrong");

    a_decade_stays: assert property (
        !clr_s && ld_n_s && st_r.count_r <= CNT_NINE
        |=> st_r.count_r <= CNT_NINE
    ) else $error("left decade range");

    a_up_illegal: assert property (
        !clr_s && ld_n_s && up_rise && dn_s && st_r.count_r == CNT_ELEVEN
        |=> st_r.count_r == CNT_SIX
    ) else $error("11 not to 6");

    a_up_thirteen: assert property (
        !clr_s && ld_n_s && up_rise && dn_s && st_r.count_r == CNT_THIRTEEN
        |=> st_r.count_r == CNT_FOUR
    ) else $error("13 not to 4");

    a_up_fifteen: assert property (
        !clr_s && ld_n_s && up_rise && dn_s && st_r.count_r == CNT_MAX
        |=> st_r.count_r == CNT_TWO
    ) else $error("15 not to 2");

    // illegal codes count down by one
    a_down_step: assert property (
        !clr_s && ld_n_s && dn_rise && up_s && st_r.count_r == CNT_MAX
        |=> st_r.count_r == CNT_FOURTEEN
    ) else $error("15 not to 14");

    a_borrow_low: assert property (
        !st_r.dn_borrow_n_r |-> st_r.count_r == CNT_ZERO
    ) else $error("borrow at nonzero");

    a_carry_low: assert property (
        !st_r.up_carry_n_r |-> st_r.count_r == CNT_NINE
    ) else $error("carry at non-nine");

    a_up_refused: assert property (
        !clr_s && ld_n_s && up_rise && !dn_s
        |=> $stable(st_r.count_r)
    ) else $error("up counted with down low");

    a_down_refused: assert property (
        !clr_s && ld_n_s && dn_rise && !up_s
        |=> $stable(st_r.count_r)
    ) else $error("down counted with up low");

    // carry follows nine and low clock
    a_carry_when: assert property (
        st_r.count_r == CNT_NINE && !up_s ##1 st_r.count_r == CNT_NINE
        |-> !st_r.up_carry_n_r
    ) else $error("carry missing");

    // borrow follows zero and low clock
    a_borrow_when: assert property (
        st_r.count_r == CNT_ZERO && !dn_s ##1 st_r.count_r == CNT_ZERO
        |-> !st_r.dn_borrow_n_r
    ) else $error("borrow missing");

    // main scenarios: wraps, load, illegal walk, refused edge
    c_up_wrap: cover property (up_rise && st_r.count_r == CNT_NINE);
    c_down_wrap: cover property (dn_rise && st_r.count_r == CNT_ZERO);
    c_load: cover property (!ld_n_s && !clr_s);
    c_illegal: cover property (up_rise && st_r.count_r == CNT_MAX);
    c_refused: cover property (up_rise && !dn_s && ld_n_s && !clr_s);
endmodule

// *** tb/count_driver.sv ***
/*
 * driving logic model for the decade counter: owns both count clocks.
 * assumes the counter samples its pins on core_clk.
 */
`timescale 1ns/1ps
module count_driver (
    // clock
    input  wire logic core_clk,
    // count clock pins
    output logic      count_up_clk,
    output logic      count_down_clk
);
    // four cycles a level: counter needs three to see a pin change
    task automatic lower(input logic up);
        if (up) count_up_clk <= 1'b0;
        else count_down_clk <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic raise();
        count_up_clk   <= 1'b1;
        count_down_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    // lets one clock rise alone, to show a refused edge
    task automatic rise_one(input logic up);
        if (up) count_up_clk <= 1'b1;
        else count_down_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        count_up_clk   = 1'b1;
        count_down_clk = 1'b1;
    end
endmodule

// *** tb/bcd_up_down_counter_tb.sv ***
/*
 * self-checking bench for the decade counter, clocks from count_driver.
 * assumes one core_clk domain and three-cycle pin sampling.
 */
`timescale 1ns/1ps
module bcd_up_down_counter_tb;
    logic       core_clk, resetn, up_clk, dn_clk, clr, ld_n, cy_n, bw_n;
    logic [3:0] pre, cnt;
    int         failures, n_compared;
    count_driver drv (.core_clk(core_clk), .count_up_clk(up_clk),
        .count_down_clk(dn_clk));
    bcd_up_down_counter dut (.core_clk(core_clk), .resetn(resetn),
        .count_up_clk(up_clk), .count_down_clk(dn_clk),
        .async_clear(clr), .load_strobe_n(ld_n),
        .preset_bit0(pre[0]), .preset_bit1(pre[1]),
        .preset_bit2(pre[2]), .preset_bit3(pre[3]),
        .count_bit0(cnt[0]), .count_bit1(cnt[1]),
        .count_bit2(cnt[2]), .count_bit3(cnt[3]),
        .up_carry_out_n(cy_n), .down_borrow_out_n(bw_n));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic load(input logic [3:0] v);
        pre  <= v;
        ld_n <= 1'b0;
        cyc(4);
        ld_n <= 1'b1;
        cyc(4);
    endtask
    task automatic step(input logic up);
        drv.lower(up);
        drv.raise();
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_up_wrap();
        load(4'h8);
        chk(cnt, 4'h8);
        step(1'b1);
        chk(cnt, 4'h9);
        drv.lower(1'b1);
        chk({3'h0, cy_n}, 4'h0);
        drv.raise();
        chk(cnt, 4'h0);
        chk({3'h0, cy_n}, 4'h1);
        $display("t_up_wrap done");
    endtask
    task automatic t_down_wrap();
        clr <= 1'b1;
        cyc(4);
        clr <= 1'b0;
        cyc(4);
        chk(cnt, 4'h0);
        drv.lower(1'b0);
        chk({3'h0, bw_n}, 4'h0);
        drv.raise();
        chk(cnt, 4'h9);
        $display("t_down_wrap done");
    endtask
    task automatic t_illegal();
        logic [3:0] seq [3][3];
        seq = '{'{4'hA, 4'hB, 4'h6}, '{4'hC, 4'hD, 4'h4},
            '{4'hE, 4'hF, 4'h2}};
        foreach (seq[i]) begin
            load(seq[i][0]);
            step(1'b1);
            chk(cnt, seq[i][1]);
            step(1'b1);
            chk(cnt, seq[i][2]);
        end
        load(4'hF);
        for (int v = 14; v >= 9; v--) begin
            step(1'b0);
            chk(cnt, 4'(v));
        end
        $display("t_illegal done");
    endtask
    task automatic t_priority();
        pre  <= 4'h5;
        ld_n <= 1'b0;
        clr  <= 1'b1;
        cyc(4);
        chk(cnt, 4'h0);
        clr <= 1'b0;
        cyc(4);
        chk(cnt, 4'h5);
        step(1'b1);
        chk(cnt, 4'h5);
        ld_n <= 1'b1;
        cyc(4);
        drv.lower(1'b0);
        drv.lower(1'b1);
        drv.rise_one(1'b1);
        chk(cnt, 4'h5);
        drv.raise();
        chk(cnt, 4'h4);
        $display("t_priority done");
    endtask
    initial begin
        {resetn, clr, failures, n_compared} = '0;
        ld_n = 1'b1;
        pre  = 4'h0;
        cyc(5);
        resetn <= 1'b1;
        cyc(1);
        t_up_wrap();
        t_down_wrap();
        t_illegal();
        t_priority();
        tally_and_finish();
    end
    initial begin
        cyc(5000);
        failures++;
        tally_and_finish();
    end
endmodule
